// >>> core/serc_pkg.sv
package serc_pkg;
    // ***********************************************
    // register word indices, byte address is index*4
    // ***********************************************
    localparam logic [7:0] ERRCFG_IDX = 8'h19;
    localparam logic [7:0] DEVCFG_IDX = 8'h1A;
    localparam logic [7:0] STATUS_IDX = 8'h18;
    localparam logic [7:0] RES0_IDX = 8'h00;
    localparam logic [7:0] MUXCFG_IDX = 8'h1B;
    localparam int ADDR_SHIFT = 2;
    localparam int NUM_CH = 4;
    localparam int CHAN_W = 2;
    // ***********************************************
    // error routing field positions
    // ***********************************************
    localparam int UR_OUT_BIT = 15;
    localparam int OR_OUT_BIT = 14;
    localparam int WD_OUT_BIT = 13;
    localparam int AH_OUT_BIT = 12;
    localparam int AL_OUT_BIT = 11;
    localparam int UR_IRQ_BIT = 7;
    localparam int OR_IRQ_BIT = 6;
    localparam int WD_IRQ_BIT = 5;
    localparam int AH_IRQ_BIT = 4;
    localparam int AL_IRQ_BIT = 3;
    localparam int ZC_IRQ_BIT = 2;
    localparam int RDY_IRQ_BIT = 0;
    localparam logic [15:0] ERRCFG_RESET = 16'h0000;
    localparam logic [15:0] ERRCFG_WMASK = 16'hF8FD;
    // ***********************************************
    // device config field positions
    // ***********************************************
    localparam int CHSEL_LSB = 14;
    localparam int SLEEP_BIT = 13;
    localparam int OVRD_BIT = 12;
    localparam int ACTSTYLE_BIT = 11;
    localparam int AMPOFF_BIT = 10;
    localparam int REFSEL_BIT = 9;
    localparam int IRQDIS_BIT = 7;
    localparam int BOOST_BIT = 6;
    localparam logic [15:0] DEVCFG_RESET = 16'h2801;
    // ***********************************************
    // status, result word and mux config field positions, bus and event codes
    // ***********************************************
    localparam int ST_CHAN_LSB = 14;
    localparam int ST_UR_BIT = 13;
    localparam int ST_OR_BIT = 12;
    localparam int ST_WD_BIT = 11;
    localparam int ST_AH_BIT = 10;
    localparam int ST_AL_BIT = 9;
    localparam int ST_ZC_BIT = 8;
    localparam int ST_RDY_BIT = 6;
    localparam int RES_UR_BIT = 15;
    localparam int RES_OR_BIT = 14;
    localparam int RES_WD_BIT = 13;
    localparam int RES_AE_BIT = 12;
    localparam int RES_DATA_W = 12;
    localparam int MUX_SCAN_BIT = 15;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [2:0] {
        SERC_EV_UR,
        SERC_EV_OR,
        SERC_EV_WD,
        SERC_EV_AH,
        SERC_EV_AL,
        SERC_EV_ZC
    } serc_event_t;
endpackage

// >>> core/serc_res_if.sv
`timescale 1ns/1ns
`default_nettype none
interface serc_res_if;
    logic wr_en;
    logic [1:0] wr_ch;
    logic [15:0] wr_data;
    logic [1:0] rd_ch;
    logic [15:0] rd_data;
    modport owner (output wr_en, output wr_ch, output wr_data, output rd_ch, input rd_data);
    modport store (input wr_en, input wr_ch, input wr_data, input rd_ch, output rd_data);
endinterface
`default_nettype wire

// >>> core/serc_result_mem.sv
`timescale 1ns/1ns
`default_nettype none
module serc_result_mem (
    input wire logic sys_clk,
    input wire logic srst,
    serc_res_if.store res
);
    import serc_pkg::*;
    logic [15:0] mem_q [NUM_CH];
    logic [15:0] rd_q;
    // read data registered so the bus mux sees a flop
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                mem_q[i] <= 16'h0000;
            end
        end else if (res.wr_en) begin
            mem_q[res.wr_ch] <= res.wr_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_q <= 16'h0000;
        end else begin
            rd_q <= mem_q[res.rd_ch];
        end
    end
    assign res.rd_data = rd_q;
endmodule
`default_nettype wire

// >>> core/serc_top.sv
// What this block does
// RULE1 - under-range routing bit set puts under-range flag into that channel's result word
// RULE2 - over-range routing bit set puts over-range flag into that channel's result word
// RULE3 - watchdog routing bit set puts timeout flag into that channel's result word
// RULE4 - amplitude-high routing bit marks amplitude error field of channel's result word
// RULE5 - amplitude-low routing bit marks amplitude error field of channel's result word
// RULE6 - under-range irq routing sets under-range status flag and asserts interrupt
// RULE7 - over-range irq routing sets over-range status flag and asserts interrupt
// RULE8 - watchdog irq routing sets timeout status flag and asserts interrupt
// RULE9 - amplitude-high irq routing sets amp-high status flag and asserts interrupt
// RULE10 - amplitude-low irq routing sets amp-low status flag and asserts interrupt
// RULE11 - zero-count irq routing sets zero-count status flag and asserts interrupt
// RULE12 - result-ready irq routing sets ready status flag and asserts interrupt
// RULE13 - scan off: convert continuously on channel chosen by two-bit select
// RULE14 - sleep bit high means asleep; resets to one
// RULE15 - drive override uses programmed per-channel drive current during conversion
// RULE16 - activation style zero drives maximum current, one uses programmed current
// RULE17 - amplitude correction off stops correction and freezes initial drive updates
// RULE18 - reference clock select: zero internal oscillator, one external pin
// RULE19 - interrupt pin disable bit stops pin assertion on status updates
// RULE20 - boosted drive clear: normal current; set: channel 0 above limit
// RULE21 - host must not set boosted drive while scanning is enabled
// RULE22 - host writes reserved bits with their documented values
// RULE23 - error and source channel stay latched until status or that result read
// RULE24 - scan enable one converts channel sequence, zero single channel
// RULE25 - interrupt pin active low, released when host reads status
// RULE26 - all routing bits reset to zero
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module serc_top (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic conv_done,
    input wire logic [serc_pkg::CHAN_W-1:0] conv_ch,
    input wire logic [serc_pkg::RES_DATA_W-1:0] conv_data,
    input wire logic [5:0] conv_err,
    input wire logic [serc_pkg::CHAN_W-1:0] scan_ch,
    input wire logic scan_round_done,
    output logic irq_out_n,
    output logic [serc_pkg::CHAN_W-1:0] active_channel,
    output logic sleep_active,
    output logic drive_override,
    output logic activation_style,
    output logic amp_correction_off,
    output logic refclk_select,
    output logic boosted_drive,
    output logic multichannel_scan_enable
);
    import serc_pkg::*;
    // ***********************************************
    // bus slave
    // ***********************************************
    logic [15:0] errcfg_q;
    logic [15:0] devcfg_q;
    logic [15:0] muxcfg_q;
    logic [15:0] status_q;
    logic dph_wr_q;
    logic dph_rd_q;
    logic [7:0] dph_idx_q;
    logic rd_pend_q;
    logic [7:0] rd_idx_q;
    logic [5:0] err_s;
    logic [5:0] err_q;
    logic done_s;
    logic done_q;
    logic [CHAN_W-1:0] ch_s;
    logic [CHAN_W-1:0] ch_q;
    logic [RES_DATA_W-1:0] data_s;
    logic [RES_DATA_W-1:0] data_q;
    logic [CHAN_W-1:0] sch_s;
    logic [CHAN_W-1:0] sch_q;
    logic rnd_s;
    logic rnd_q;
    serc_res_if res();
    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[ADDR_SHIFT +: 8];
    endfunction
    wire logic addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic status_rd = rd_pend_q && rd_idx_q == STATUS_IDX;
    wire logic result_rd = rd_pend_q && rd_idx_q[7:CHAN_W] == RES0_IDX[7:CHAN_W];
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dph_wr_q <= 1'b0;
            dph_rd_q <= 1'b0;
            dph_idx_q <= 8'h00;
        end else begin
            dph_wr_q <= addr_ok && hwrite;
            dph_rd_q <= addr_ok && !hwrite;
            // index held through the data phase, the master may move haddr on
            if (addr_ok) begin
                dph_idx_q <= word_index(haddr);
            end
        end
    end
    // two wait states on reads: result memory flop first, then the hrdata flop
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_pend_q <= 1'b0;
            rd_idx_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
        end else begin
            rd_pend_q <= dph_rd_q;
            rd_idx_q <= dph_idx_q;
            hreadyout <= !(addr_ok && !hwrite) && !dph_rd_q;
            if (rd_pend_q) begin
                if (rd_idx_q == ERRCFG_IDX) begin
                    hrdata <= {16'h0000, errcfg_q};
                end else if (rd_idx_q == DEVCFG_IDX) begin
                    hrdata <= {16'h0000, devcfg_q};
                end else if (rd_idx_q == MUXCFG_IDX) begin
                    hrdata <= {16'h0000, muxcfg_q};
                end else if (rd_idx_q == STATUS_IDX) begin
                    hrdata <= {16'h0000, status_q};
                end else if (result_rd) begin
                    hrdata <= {16'h0000, res.rd_data};
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end
    // ***********************************************
    // configuration registers
    // ***********************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            errcfg_q <= ERRCFG_RESET; // RULE26
            devcfg_q <= DEVCFG_RESET; // RULE14
            muxcfg_q <= 16'h0000;
        end else if (dph_wr_q) begin
            // errcfg reserved bits 10 to 8 and bit 1 kept zero whatever the host writes, devcfg and muxcfg taken as written
            if (dph_idx_q == ERRCFG_IDX) begin
                errcfg_q <= hwdata[15:0] & ERRCFG_WMASK; // RULE22
            end
            if (dph_idx_q == DEVCFG_IDX) begin
                devcfg_q <= hwdata[15:0];
            end
            if (dph_idx_q == MUXCFG_IDX) begin
                muxcfg_q <= hwdata[15:0];
            end
        end
    end
    // ***********************************************
    // event synchronisers
    // ***********************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            err_s <= 6'h00;
            err_q <= 6'h00;
            done_s <= 1'b0;
            done_q <= 1'b0;
            ch_s <= 2'h0;
            ch_q <= 2'h0;
            data_s <= 12'h000;
            data_q <= 12'h000;
            sch_s <= 2'h0;
            sch_q <= 2'h0;
            rnd_s <= 1'b0;
            rnd_q <= 1'b0;
        end else begin
            err_s <= conv_err;
            err_q <= err_s;
            done_s <= conv_done;
            done_q <= done_s;
            ch_s <= conv_ch;
            ch_q <= ch_s;
            data_s <= conv_data;
            data_q <= data_s;
            sch_s <= scan_ch;
            sch_q <= sch_s;
            rnd_s <= scan_round_done;
            rnd_q <= rnd_s;
        end
    end
    // ***********************************************
    // result words
    // ***********************************************
    logic [15:0] res_word;
    always_comb begin
        res_word = {4'h0, data_q};
        res_word[RES_UR_BIT] = err_q[SERC_EV_UR] && errcfg_q[UR_OUT_BIT]; // RULE1
        res_word[RES_OR_BIT] = err_q[SERC_EV_OR] && errcfg_q[OR_OUT_BIT]; // RULE2
        res_word[RES_WD_BIT] = err_q[SERC_EV_WD] && errcfg_q[WD_OUT_BIT]; // RULE3
        res_word[RES_AE_BIT] = (err_q[SERC_EV_AH] && errcfg_q[AH_OUT_BIT]) // RULE4
            || (err_q[SERC_EV_AL] && errcfg_q[AL_OUT_BIT]); // RULE5
    end
    assign res.wr_en = done_q && !devcfg_q[SLEEP_BIT];
    assign res.wr_ch = ch_q;
    assign res.wr_data = res_word;
    assign res.rd_ch = dph_idx_q[CHAN_W-1:0];
    serc_result_mem u_mem (
        .sys_clk(sys_clk),
        .srst(srst),
        .res(res)
    );
    // ***********************************************
    // status latch
    // ***********************************************
    logic [5:0] ev_routed;
    logic rdy_routed;
    logic rdy_event;
    always_comb begin
        ev_routed = 6'h00;
        ev_routed[SERC_EV_UR] = err_q[SERC_EV_UR] && errcfg_q[UR_IRQ_BIT]; // RULE6
        ev_routed[SERC_EV_OR] = err_q[SERC_EV_OR] && errcfg_q[OR_IRQ_BIT]; // RULE7
        ev_routed[SERC_EV_WD] = err_q[SERC_EV_WD] && errcfg_q[WD_IRQ_BIT]; // RULE8
        ev_routed[SERC_EV_AH] = err_q[SERC_EV_AH] && errcfg_q[AH_IRQ_BIT]; // RULE9
        ev_routed[SERC_EV_AL] = err_q[SERC_EV_AL] && errcfg_q[AL_IRQ_BIT]; // RULE10
        ev_routed[SERC_EV_ZC] = err_q[SERC_EV_ZC] && errcfg_q[ZC_IRQ_BIT]; // RULE11
        if (!res.wr_en) begin
            ev_routed = 6'h00;
        end
    end
    // in scan mode ready means the whole round is in
    assign rdy_event = muxcfg_q[MUX_SCAN_BIT] ? (rnd_q && !devcfg_q[SLEEP_BIT]) : res.wr_en; // RULE24
    assign rdy_routed = rdy_event && errcfg_q[RDY_IRQ_BIT]; // RULE12
    wire logic err_clear = status_rd
        || (result_rd && rd_idx_q[CHAN_W-1:0] == status_q[ST_CHAN_LSB +: CHAN_W]);
    wire logic any_new = |ev_routed || rdy_routed;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_q <= 16'h0000;
        end else begin
            // new event beats the read clear in the same cycle
            if (err_clear) begin // RULE23
                status_q[ST_UR_BIT:ST_ZC_BIT] <= 6'h00;
                status_q[ST_RDY_BIT] <= 1'b0;
            end
            if (|ev_routed) begin
                status_q[ST_UR_BIT] <= ev_routed[SERC_EV_UR] || (status_q[ST_UR_BIT] && !err_clear);
                status_q[ST_OR_BIT] <= ev_routed[SERC_EV_OR] || (status_q[ST_OR_BIT] && !err_clear);
                status_q[ST_WD_BIT] <= ev_routed[SERC_EV_WD] || (status_q[ST_WD_BIT] && !err_clear);
                status_q[ST_AH_BIT] <= ev_routed[SERC_EV_AH] || (status_q[ST_AH_BIT] && !err_clear);
                status_q[ST_AL_BIT] <= ev_routed[SERC_EV_AL] || (status_q[ST_AL_BIT] && !err_clear);
                status_q[ST_ZC_BIT] <= ev_routed[SERC_EV_ZC] || (status_q[ST_ZC_BIT] && !err_clear);
                status_q[ST_CHAN_LSB +: CHAN_W] <= ch_q; // RULE23
            end
            if (rdy_routed) begin
                status_q[ST_RDY_BIT] <= 1'b1;
            end
        end
    end
    // ***********************************************
    // interrupt pin
    // ***********************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_out_n <= 1'b1;
        end else if (any_new && !devcfg_q[IRQDIS_BIT]) begin // RULE19
            irq_out_n <= 1'b0;
        end else if (status_rd) begin // RULE25
            irq_out_n <= 1'b1;
        end
    end
    // ***********************************************
    // control outputs to the conversion core
    // ***********************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            active_channel <= 2'h0;
            sleep_active <= 1'b1;
            drive_override <= 1'b0;
            activation_style <= 1'b1;
            amp_correction_off <= 1'b0;
            refclk_select <= 1'b0;
            boosted_drive <= 1'b0;
            multichannel_scan_enable <= 1'b0;
        end else begin
            multichannel_scan_enable <= muxcfg_q[MUX_SCAN_BIT]; // RULE24
            active_channel <= muxcfg_q[MUX_SCAN_BIT] ? sch_q : devcfg_q[CHSEL_LSB +: CHAN_W]; // RULE13
            sleep_active <= devcfg_q[SLEEP_BIT]; // RULE14
            drive_override <= devcfg_q[OVRD_BIT]; // RULE15
            activation_style <= devcfg_q[ACTSTYLE_BIT]; // RULE16
            amp_correction_off <= devcfg_q[AMPOFF_BIT]; // RULE17
            refclk_select <= devcfg_q[REFSEL_BIT]; // RULE18
            // boost is channel 0 only and unsupported while scanning
            boosted_drive <= devcfg_q[BOOST_BIT] && !muxcfg_q[MUX_SCAN_BIT]; // RULE20 RULE21
        end
    end
endmodule
`default_nettype wire

// >>> tb/serc_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module serc_top_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq_out_n,
    input wire logic [1:0] active_channel,
    input wire logic sleep_active,
    input wire logic drive_override,
    input wire logic activation_style,
    input wire logic amp_correction_off,
    input wire logic refclk_select,
    input wire logic boosted_drive,
    input wire logic multichannel_scan_enable
);
    import serc_pkg::*;
    // ****************
    // bus shadow
    // ****************
    logic tk, wcfg_q;
    logic [15:0] cfg_q;
    logic [1:0] quiet_q;
    logic [2:0] age_q;
    assign tk = hsel && hready && htrans == HTRANS_NONSEQ;
    always_ff @(posedge sys_clk) begin
        if (srst) wcfg_q <= 1'b0;
        else if (hready) wcfg_q <= tk && hwrite && haddr[9:2] == DEVCFG_IDX;
    end
    // own copy of the config word, so outputs are judged against what was written
    always_ff @(posedge sys_clk) begin
        if (srst) cfg_q <= DEVCFG_RESET;
        else if (wcfg_q && hready) cfg_q <= hwdata[15:0];
    end
    // outputs get three cycles to settle after a config write
    always_ff @(posedge sys_clk) begin
        if (srst || wcfg_q) quiet_q <= 2'h0;
        else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (srst || (tk && !hwrite && haddr[9:2] == STATUS_IDX)) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_hresp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
    a_irq_release: assert property ($rose(irq_out_n) |-> age_q <= 3'h4) else $error("irq freed unasked");
    a_status_frees: assert property (tk && !hwrite && haddr[9:2] == STATUS_IDX && !irq_out_n
        |-> ##[1:4] irq_out_n) else $error("irq not freed by status read");
    a_irq_mute: assert property ($fell(irq_out_n) |-> !cfg_q[IRQDIS_BIT]) else $error("irq while disabled");
    a_chan_follow: assert property (quiet_q == 2'h3 && !multichannel_scan_enable
        |-> active_channel == cfg_q[15:14])
        else $error("channel select mismatch");
    a_sleep_follow: assert property (quiet_q == 2'h3 |-> sleep_active == cfg_q[SLEEP_BIT])
        else $error("sleep mismatch");
    a_setup_follow: assert property (quiet_q == 2'h3 |-> {drive_override, activation_style,
        amp_correction_off, refclk_select} == cfg_q[12:9]) else $error("drive setup mismatch");
    a_boost_scan: assert property (multichannel_scan_enable |-> !boosted_drive) else $error("boost in scan");
    c_status_read: cover property (tk && !hwrite && haddr[9:2] == STATUS_IDX && !irq_out_n);
    c_irq_fall: cover property ($fell(irq_out_n));
    c_scan_boost: cover property (multichannel_scan_enable && cfg_q[BOOST_BIT]);
endmodule
bind serc_top serc_top_checker chk_u (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .irq_out_n(irq_out_n), .active_channel(active_channel), .sleep_active(sleep_active),
    .drive_override(drive_override), .activation_style(activation_style),
    .amp_correction_off(amp_correction_off), .refclk_select(refclk_select),
    .boosted_drive(boosted_drive), .multichannel_scan_enable(multichannel_scan_enable));
`default_nettype wire

// >>> tb/serc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module serc_core_model (
    input wire logic sys_clk,
    output logic conv_done,
    output logic [1:0] conv_ch,
    output logic [11:0] conv_data,
    output logic [5:0] conv_err,
    output logic [1:0] scan_ch,
    output logic scan_round_done
);
    // ****************
    // conversion core
    // ****************
    initial begin
        conv_done = 1'b0;
        conv_ch = 2'h0;
        conv_data = 12'h0;
        conv_err = 6'h0;
        scan_ch = 2'h0;
        scan_round_done = 1'b0;
    end
    task automatic fire(input logic [1:0] c, input logic [11:0] d, input logic [5:0] e);
        @(posedge sys_clk);
        conv_ch <= c;
        conv_data <= d;
        conv_err <= e;
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        repeat (4) @(posedge sys_clk);
        // hold time over: show garbage so a late sample cannot pass by luck
        conv_ch <= ~c;
        conv_data <= ~d;
        conv_err <= ~e;
    endtask
    task automatic round();
        @(posedge sys_clk);
        scan_ch <= scan_ch + 2'h1;
        scan_round_done <= 1'b1;
        @(posedge sys_clk);
        scan_round_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_sensing_error_routing_config.sv
`timescale 1ns/1ns
`default_nettype none
module test_sensing_error_routing_config;
    import serc_pkg::*;
    logic sys_clk, srst, hsel, hwrite, hreadyout, hresp, irq_out_n, conv_done, scan_round_done;
    logic sleep_active, drive_override, activation_style, amp_correction_off, refclk_select;
    logic boosted_drive, multichannel_scan_enable;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, active_channel, conv_ch, scan_ch, ch, lc;
    logic [2:0] hsize;
    logic [11:0] conv_data, d;
    logic [5:0] conv_err, er;
    logic [15:0] ec, dev, st;
    int fails, compares;
    serc_top dut_u (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done), .conv_ch(conv_ch),
        .conv_data(conv_data), .conv_err(conv_err), .scan_ch(scan_ch), .scan_round_done(scan_round_done),
        .irq_out_n(irq_out_n), .active_channel(active_channel), .sleep_active(sleep_active),
        .drive_override(drive_override), .activation_style(activation_style),
        .amp_correction_off(amp_correction_off), .refclk_select(refclk_select),
        .boosted_drive(boosted_drive), .multichannel_scan_enable(multichannel_scan_enable));
    serc_core_model core_u (.sys_clk(sys_clk), .conv_done(conv_done), .conv_ch(conv_ch),
        .conv_data(conv_data), .conv_err(conv_err), .scan_ch(scan_ch), .scan_round_done(scan_round_done));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ****************
    // helpers
    // ****************
    task automatic summarize();
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic waitrdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            fails++;
            summarize();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        waitrdy();
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        waitrdy();
        rd = hrdata;
    endtask
    function automatic logic [15:0] exp_st(input logic [15:0] e, input logic [5:0] r, input logic [1:0] c);
        logic [15:0] s;
        s = 16'h0;
        for (int i = 0; i < 6; i++) s[ST_UR_BIT - i] = r[i] & e[UR_IRQ_BIT - i];
        s[ST_RDY_BIT] = e[RDY_IRQ_BIT];
        // only errors name a source channel, ready alone leaves it as it was
        if (s[ST_UR_BIT:ST_ZC_BIT] != 6'h0) s[15:14] = c;
        return s;
    endfunction
    function automatic logic [31:0] exp_res(input logic [15:0] e, input logic [5:0] r, input logic [11:0] x);
        return {16'h0, r[0] & e[15], r[1] & e[14], r[2] & e[13], (r[3] & e[12]) | (r[4] & e[11]), x};
    endfunction
    // ****************
    // main sequence
    // ****************
    initial begin
        fails = 0;
        compares = 0;
        lc = 2'h0;
        void'($urandom(32'h7723));
        srst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk("irq_idle", 32'h1, irq_out_n);
        chk("sleep_rst", 32'h1, sleep_active);
        bus(1'b0, ERRCFG_IDX, 16'h0);
        chk("errcfg_rst", 32'h0, rd);
        bus(1'b0, DEVCFG_IDX, 16'h0);
        chk("devcfg_rst", 32'h2801, rd);
        bus(1'b1, 8'h30, 16'hFFFF);
        bus(1'b0, 8'h30, 16'h0);
        chk("unmapped", 32'h0, rd);
        // k 3 sleeps, k 4 routes nothing, k 6 routes all, k 7 mutes the pin
        for (int k = 0; k < 16; k++) begin
            ch = 2'($urandom);
            d = 12'($urandom);
            er = (k == 5) ? 6'h3F : 6'($urandom);
            ec = (k == 4) ? 16'h0 : (k == 6) ? ERRCFG_WMASK : (16'($urandom) & ERRCFG_WMASK);
            dev = {ch, k == 3, 4'($urandom), 1'b0, k == 7, 1'($urandom), 6'h01};
            bus(1'b1, ERRCFG_IDX, ec);
            bus(1'b1, DEVCFG_IDX, dev);
            repeat (3) @(posedge sys_clk);
            chk("dev_out", {ch, dev[13:9], dev[6]}, {active_channel, sleep_active, drive_override, activation_style,
                amp_correction_off, refclk_select, boosted_drive});
            bus(1'b0, ERRCFG_IDX, 16'h0);
            chk("errcfg", {16'h0, ec}, rd);
            st = (k == 3) ? 16'h0 : exp_st(ec, er, ch);
            if (st[ST_UR_BIT:ST_ZC_BIT] != 6'h0) lc = ch;
            core_u.fire(ch, d, er);
            repeat (10) @(posedge sys_clk);
            chk("irq_n", !(|st && !dev[IRQDIS_BIT]), irq_out_n);
            if (k % 3 == 1) begin
                bus(1'b0, RES0_IDX + 8'(ch), 16'h0);
                chk("res_first", exp_res(ec, er, d), rd);
                chk("irq_hold", !(|st && !dev[IRQDIS_BIT]), irq_out_n);
                if (lc == ch) st = 16'h0;
            end
            bus(1'b0, STATUS_IDX, 16'h0);
            chk("status", {16'h0, st}, rd & (|st[ST_UR_BIT:ST_ZC_BIT] ? 32'hFF40 : 32'h3F40));
            @(posedge sys_clk);
            chk("irq_free", 32'h1, irq_out_n);
            if (k % 3 != 1 && k != 3) begin
                bus(1'b0, RES0_IDX + 8'(ch), 16'h0);
                chk("result", exp_res(ec, er, d), rd);
            end
        end
        bus(1'b1, DEVCFG_IDX, 16'h0001);
        bus(1'b1, MUXCFG_IDX, 16'h8000);
        bus(1'b1, ERRCFG_IDX, 16'h0001);
        // boost asked for while scanning on purpose: the block must keep it off
        bus(1'b1, DEVCFG_IDX, 16'h0041);
        repeat (3) @(posedge sys_clk);
        chk("scan_boost", 32'h2, {multichannel_scan_enable, boosted_drive});
        core_u.round();
        repeat (10) @(posedge sys_clk);
        chk("scan_irq", 32'h0, irq_out_n);
        bus(1'b0, STATUS_IDX, 16'h0);
        chk("scan_ready", 32'h40, rd & 32'h40);
        summarize();
    end
endmodule
`default_nettype wire
